// ### hdl/dpwa_defs.svh
`ifndef DPWA_DEFS_SVH
`define DPWA_DEFS_SVH

`define DPWA_DATA_W         16
`define DPWA_ADDR_W         13

`define DPWA_CLK_PERIOD_NS  100
`define DPWA_T_AS_NS        0
`define DPWA_T_WP_NS        12
`define DPWA_T_WZ_NS        10
`define DPWA_T_DW_NS        10
`define DPWA_T_WR_NS        0
`define DPWA_T_WH_NS        12
`define DPWA_T_SWRD_NS      5
`define DPWA_T_RD_ACC_NS    25

`define DPWA_SYNC_LAT       3

`define DPWA_BUSY_RST       1'h1
`define DPWA_DATA_RST       16'h0000

`endif

// ### hdl/dpwa_pkg.sv
package dpwa_pkg;

	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_END,
		ST_READ,
		ST_RECOV
	} dpwa_state_t;

	typedef logic [15:0] dpwa_data_t;
	typedef logic [12:0] dpwa_addr_t;
	typedef logic [1:0]  dpwa_bsel_t;

endpackage

// ### hdl/dpwa_pin_if.sv
`timescale 1ns/100ps
interface dpwa_pin_if;
	import dpwa_pkg::*;
	logic       busy_n;
	dpwa_data_t rdata;
	modport src (output busy_n, output rdata);
	modport dst (input busy_n, input rdata);
endinterface

// ### hdl/dpwa_pin_sync.sv
`timescale 1ns/100ps
`include "dpwa_defs.svh"
module dpwa_pin_sync (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_busy_n,
	input  wire dpwa_pkg::dpwa_data_t i_data,
	dpwa_pin_if.src                pins
);
	import dpwa_pkg::*;

	logic [16:0] s1_ff;
	logic [16:0] s2_ff;
	logic [16:0] s3_ff;
	logic [16:0] out_ff;
	logic [16:0] agree;

	// Three-stage chain; only the second stage reads the first
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_ff <= {`DPWA_BUSY_RST, `DPWA_DATA_RST};
			s2_ff <= {`DPWA_BUSY_RST, `DPWA_DATA_RST};
			s3_ff <= {`DPWA_BUSY_RST, `DPWA_DATA_RST};
		end else begin
			s1_ff <= {i_busy_n, i_data};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A bit moves only once stages two and three agree, filtering metastable glitches
	assign agree = ~(s2_ff ^ s3_ff);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			out_ff <= {`DPWA_BUSY_RST, `DPWA_DATA_RST};
		end else begin
			out_ff <= (s3_ff & agree) | (out_ff & ~agree);
		end
	end

	assign pins.busy_n = out_ff[16];
	assign pins.rdata  = out_ff[15:0];
endmodule

// ### hdl/dpwa_host.sv
`timescale 1ns/100ps
`include "dpwa_defs.svh"
module dpwa_host (
	input  wire logic                 I_CORE_CLK,
	input  wire logic                 I_NRST,
	// User side
	input  wire logic                 I_REQ,
	input  wire logic                 I_WRITE,
	input  wire logic                 I_SEM,
	input  wire dpwa_pkg::dpwa_addr_t I_ADDR,
	input  wire dpwa_pkg::dpwa_data_t I_WDATA,
	input  wire dpwa_pkg::dpwa_bsel_t I_BYTE_EN,
	output logic                      O_READY,
	output logic                      O_DONE,
	output dpwa_pkg::dpwa_data_t      O_RDATA,
	// Memory port pins
	output dpwa_pkg::dpwa_addr_t      O_ADDR,
	output logic                      O_PORT_SEL_N,
	output logic                      O_WRITE_N,
	output logic                      O_OUT_EN_N,
	output logic                      O_UPPER_BYTE_SELECT_N,
	output logic                      O_LOWER_BYTE_SELECT_N,
	output logic                      O_FLAG_SELECT_N,
	output dpwa_pkg::dpwa_data_t      O_DATA,
	output logic                      O_DATA_OE_N,
	input  wire dpwa_pkg::dpwa_data_t I_DATA,
	input  wire logic                 I_BUSY_N
);
	import dpwa_pkg::*;

	// Nanoseconds to whole clock cycles, rounded up, never below one
	function automatic logic [3:0] to_cyc(input int ns);
		int c;
		c = (ns + `DPWA_CLK_PERIOD_NS - 1) / `DPWA_CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return c[3:0];
	endfunction

	function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
		return (a > b) ? a : b;
	endfunction

	localparam logic [3:0] AS_CYC    = to_cyc(`DPWA_T_AS_NS);
	localparam logic [3:0] WZ_CYC    = to_cyc(`DPWA_T_WZ_NS);
	localparam logic [3:0] PULSE_CYC = max4(to_cyc(`DPWA_T_WP_NS),
		4'(WZ_CYC + to_cyc(`DPWA_T_DW_NS)));
	localparam logic [3:0] WH_CYC    = to_cyc(`DPWA_T_WH_NS);
	localparam logic [3:0] WR_CYC    = max4(to_cyc(`DPWA_T_WR_NS),
		to_cyc(`DPWA_T_SWRD_NS));
	// The sync output stage adds one cycle beyond the three-stage chain
	localparam logic [3:0] RD_CYC    = 4'(to_cyc(`DPWA_T_RD_ACC_NS) + `DPWA_SYNC_LAT + 1);

	dpwa_pin_if pins ();

	dpwa_pin_sync u_sync (
		.i_clk    (I_CORE_CLK),
		.i_nrst   (I_NRST),
		.i_busy_n (I_BUSY_N),
		.i_data   (I_DATA),
		.pins     (pins)
	);

	dpwa_state_t state_ff;
	dpwa_state_t nxt_state;
	logic [3:0]  cnt_ff;
	logic [3:0]  hold_ff;
	logic        wr_ff;
	logic        sem_ff;
	dpwa_bsel_t  bsel_ff;
	dpwa_data_t  wdata_ff;
	dpwa_addr_t  addr_ff;
	logic        cs_n_ff;
	logic        we_n_ff;
	logic        oe_n_ff;
	logic        ub_n_ff;
	logic        lb_n_ff;
	logic        fs_n_ff;
	logic        doe_n_ff;
	dpwa_data_t  rdata_ff;
	logic        done_ff;
	logic        take;
	logic        busy;
	logic        strobe_done;

	assign O_READY     = (state_ff == ST_IDLE);
	assign take        = I_REQ & O_READY;
	assign busy        = ~pins.busy_n;
	// Strobe may rise only after the full pulse and the hold after busy release
	assign strobe_done = (cnt_ff >= PULSE_CYC) && (hold_ff == 4'h0) && !busy;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_ff >= AS_CYC) begin
					nxt_state = wr_ff ? ST_STROBE : ST_READ;
				end
			end
			ST_STROBE: begin
				if (strobe_done) begin
					nxt_state = ST_END;
				end
			end
			ST_READ: begin
				if (cnt_ff >= RD_CYC) begin
					nxt_state = ST_END;
				end
			end
			ST_END: begin
				nxt_state = ST_RECOV;
			end
			ST_RECOV: begin
				if (cnt_ff >= WR_CYC) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Phase counter restarts on every state change
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cnt_ff <= 4'h0;
		end else if (nxt_state != state_ff) begin
			cnt_ff <= 4'h1;
		end else if (cnt_ff != 4'hF) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// Busy from the arbiter blocks the write; hold restarts each busy cycle
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			hold_ff <= 4'h0;
		end else if (state_ff != ST_STROBE) begin
			hold_ff <= 4'h0;
		end else if (busy) begin
			hold_ff <= WH_CYC;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
		end
	end

	// Request capture; an array write with no byte lane picks both lanes
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			wr_ff    <= 1'b0;
			sem_ff   <= 1'b0;
			bsel_ff  <= 2'h0;
			wdata_ff <= `DPWA_DATA_RST;
		end else if (take) begin
			wr_ff    <= I_WRITE;
			sem_ff   <= I_SEM;
			bsel_ff  <= ((I_BYTE_EN == 2'h0) || !I_WRITE) ? 2'h3 : I_BYTE_EN;
			wdata_ff <= I_SEM ? {16{I_WDATA[0]}} : I_WDATA;
		end
	end

	// Address moves only in idle, where every strobe is high
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			addr_ff <= 13'h0000;
		end else if (take) begin
			addr_ff <= I_ADDR;
		end
	end

	// Selects and strobe fall together so the device never turns its drivers on during a write
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cs_n_ff <= 1'b1;
			fs_n_ff <= 1'b1;
			ub_n_ff <= 1'b1;
			lb_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else begin
			case (nxt_state)
				ST_STROBE, ST_READ: begin
					cs_n_ff <= sem_ff;
					fs_n_ff <= !sem_ff;
					ub_n_ff <= sem_ff | !bsel_ff[1];
					lb_n_ff <= sem_ff | !bsel_ff[0];
					we_n_ff <= (nxt_state != ST_STROBE);
					oe_n_ff <= (nxt_state != ST_READ);
				end
				default: begin
					// Select and strobe rise on one edge, ending the write cleanly
					cs_n_ff <= 1'b1;
					fs_n_ff <= 1'b1;
					ub_n_ff <= 1'b1;
					lb_n_ff <= 1'b1;
					we_n_ff <= 1'b1;
					oe_n_ff <= 1'b1;
				end
			endcase
		end
	end

	// Data drive waits out the device turn-off and holds until recovery ends
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			doe_n_ff <= 1'b1;
		end else if (state_ff == ST_STROBE && cnt_ff >= WZ_CYC) begin
			doe_n_ff <= 1'b0;
		end else if (state_ff != ST_STROBE && state_ff != ST_END) begin
			doe_n_ff <= 1'b1;
		end
	end

	// Read data is sampled once the access and sync latency have passed
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rdata_ff <= `DPWA_DATA_RST;
		end else if (state_ff == ST_READ && nxt_state == ST_END) begin
			rdata_ff <= pins.rdata;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (state_ff == ST_RECOV) && (nxt_state == ST_IDLE);
		end
	end

	assign O_ADDR                = addr_ff;
	assign O_PORT_SEL_N          = cs_n_ff;
	assign O_WRITE_N             = we_n_ff;
	assign O_OUT_EN_N            = oe_n_ff;
	assign O_UPPER_BYTE_SELECT_N = ub_n_ff;
	assign O_LOWER_BYTE_SELECT_N = lb_n_ff;
	assign O_FLAG_SELECT_N       = fs_n_ff;
	assign O_DATA                = wdata_ff;
	assign O_DATA_OE_N           = doe_n_ff;
	assign O_RDATA               = rdata_ff;
	assign O_DONE                = done_ff;
endmodule

// ### verif/dpwa_host_chk.sv
`timescale 1ns/100ps
module dpwa_host_chk (
	input  wire logic                 I_CORE_CLK,
	input  wire logic                 I_NRST,
	input  wire dpwa_pkg::dpwa_addr_t O_ADDR,
	input  wire logic                 O_PORT_SEL_N,
	input  wire logic                 O_WRITE_N,
	input  wire logic                 O_OUT_EN_N,
	input  wire logic                 O_UPPER_BYTE_SELECT_N,
	input  wire logic                 O_LOWER_BYTE_SELECT_N,
	input  wire logic                 O_FLAG_SELECT_N,
	input  wire logic                 O_DATA_OE_N,
	input  wire logic                 I_BUSY_N
);
	import dpwa_pkg::*;
	logic both_hi;
	// Both lanes idle means the array side is off
	assign both_hi = O_UPPER_BYTE_SELECT_N & O_LOWER_BYTE_SELECT_N;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_NRST);
	// Busy held over a live strobe, then let go
	sequence s_blocked;
		(!O_WRITE_N && !I_BUSY_N) [*3] ##1 I_BUSY_N;
	endsequence
	a_addr_quiet: assert property (!$stable(O_ADDR) |-> O_WRITE_N && $past(O_WRITE_N))
		else $error("address moved during strobe");
	a_no_contend: assert property (!O_DATA_OE_N |-> O_OUT_EN_N)
		else $error("host drives while device output enabled");
	a_data_late: assert property ($fell(O_WRITE_N) |-> O_DATA_OE_N ##1 !O_DATA_OE_N)
		else $error("write data not on second strobe cycle");
	a_pulse_width: assert property ($fell(O_WRITE_N) |=> !O_WRITE_N)
		else $error("write pulse shorter than two cycles");
	a_data_hold: assert property ($rose(O_WRITE_N) |-> !O_DATA_OE_N [*2] ##1 O_DATA_OE_N)
		else $error("write data not held through recovery");
	a_mode_legal: assert property (!O_WRITE_N |->
		(!O_PORT_SEL_N && !both_hi && O_FLAG_SELECT_N) ||
		(O_PORT_SEL_N && both_hi && !O_FLAG_SELECT_N))
		else $error("illegal select combination in write");
	a_mode_held: assert property (!O_WRITE_N && $past(!O_WRITE_N) |->
		$stable({O_PORT_SEL_N, both_hi, O_FLAG_SELECT_N}))
		else $error("select combination changed mid write");
	a_busy_hold: assert property (s_blocked |-> !O_WRITE_N [*2])
		else $error("strobe ended too soon after busy release");
endmodule

bind dpwa_host dpwa_host_chk u_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .O_ADDR(O_ADDR),
	.O_PORT_SEL_N(O_PORT_SEL_N), .O_WRITE_N(O_WRITE_N), .O_OUT_EN_N(O_OUT_EN_N),
	.O_UPPER_BYTE_SELECT_N(O_UPPER_BYTE_SELECT_N),
	.O_LOWER_BYTE_SELECT_N(O_LOWER_BYTE_SELECT_N),
	.O_FLAG_SELECT_N(O_FLAG_SELECT_N), .O_DATA_OE_N(O_DATA_OE_N), .I_BUSY_N(I_BUSY_N)
);

// ### verif/dpwa_dev_model.sv
`timescale 1ns/100ps
module dpwa_dev_model (
	input  wire dpwa_pkg::dpwa_addr_t i_addr,
	input  wire logic                 i_port_sel_n,
	input  wire logic                 i_write_n,
	input  wire logic                 i_out_en_n,
	input  wire logic                 i_ub_n,
	input  wire logic                 i_lb_n,
	input  wire logic                 i_flag_sel_n,
	input  wire dpwa_pkg::dpwa_data_t i_data,
	input  wire logic                 i_data_oe_n,
	input  wire logic                 i_busy_n_cmd,
	output dpwa_pkg::dpwa_data_t      o_data,
	output logic                      o_busy_n
);
	import dpwa_pkg::*;
	// Whole array readable at any time from this port; array writes commit only while busy is high
	dpwa_data_t mem [0:8191];
	logic [7:0] flag = 8'hFF;
	logic       arr_wr, sem_wr, rd_en;
	dpwa_data_t rval, wd;
	dpwa_addr_t wa;
	dpwa_bsel_t wb;
	// Array write is live only while select, strobe and a lane are low together; semaphore write needs both lanes high
	assign arr_wr = !i_port_sel_n & !i_write_n & !(i_ub_n & i_lb_n);
	assign sem_wr = !i_flag_sel_n & !i_write_n & i_port_sel_n & i_ub_n & i_lb_n;
	// Drivers stay off while the strobe is low; released lines show a wrong pattern
	assign rd_en = !i_out_en_n & i_write_n & (!i_port_sel_n | !i_flag_sel_n);
	assign rval = !i_flag_sel_n ? {16{flag[i_addr[2:0]]}} : mem[i_addr];
	assign #25 o_data = rd_en ? rval : ~rval;
	// Busy follows the command after the match delay
	assign #15 o_busy_n = i_busy_n_cmd;
	// Track the open write so the end edge sees its lanes
	always @* begin
		if (arr_wr | sem_wr) begin
			wa = i_addr;
			wb = {i_ub_n, i_lb_n};
			// An undriven bus reads back inverted, so late data is caught
			wd = i_data_oe_n ? ~i_data : i_data;
		end
	end
	// Commit on the earlier rising edge; busy low inhibits the array commit only
	always @(negedge arr_wr) begin
		if (i_busy_n_cmd) begin
			if (!wb[1]) mem[wa][15:8] = wd[15:8];
			if (!wb[0]) mem[wa][7:0] = wd[7:0];
		end
	end
	always @(negedge sem_wr) begin
		flag[wa[2:0]] = wd[0];
	end
endmodule

// ### verif/dual_port_write_arbitration_tb_top.sv
`timescale 1ns/100ps
module dual_port_write_arbitration_tb_top;
	import dpwa_pkg::*;
	logic       clk = 0, nrst = 0, req = 0, wr = 0, flag_select_n = 0, busy_cmd = 1;
	dpwa_addr_t addr = 13'h0000;
	dpwa_data_t wd = 16'h0000;
	dpwa_bsel_t be = 2'h0;
	logic       ready, done, ps_n, we_n, oe_n, ub_n, lb_n, fs_n, hoe_n, dbusy_n;
	dpwa_addr_t paddr;
	dpwa_data_t rdata, hdata, ddata;
	int         bad_count = 0, n_checks = 0, n;
	// Free running core clock
	always #50 clk = ~clk;
	dpwa_host u_dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_REQ(req), .I_WRITE(wr),
		.I_SEM(flag_select_n), .I_ADDR(addr), .I_WDATA(wd), .I_BYTE_EN(be), .O_READY(ready),
		.O_DONE(done), .O_RDATA(rdata), .O_ADDR(paddr), .O_PORT_SEL_N(ps_n),
		.O_WRITE_N(we_n), .O_OUT_EN_N(oe_n), .O_UPPER_BYTE_SELECT_N(ub_n),
		.O_LOWER_BYTE_SELECT_N(lb_n), .O_FLAG_SELECT_N(fs_n), .O_DATA(hdata),
		.O_DATA_OE_N(hoe_n), .I_DATA(ddata), .I_BUSY_N(dbusy_n));
	dpwa_dev_model u_dev (.i_addr(paddr), .i_port_sel_n(ps_n), .i_write_n(we_n),
		.i_out_en_n(oe_n), .i_ub_n(ub_n), .i_lb_n(lb_n), .i_flag_sel_n(fs_n),
		.i_data(hdata), .i_data_oe_n(hoe_n), .i_busy_n_cmd(busy_cmd), .o_data(ddata),
		.o_busy_n(dbusy_n));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One user transfer; k counts cycles from the taking edge to done
	task automatic op(input logic w, s, input dpwa_addr_t a, input dpwa_data_t d,
			input dpwa_bsel_t b, output int k);
		int g;
		g = 0;
		k = 0;
		@(negedge clk);
		while (ready !== 1'b1 && g < 50) begin
			@(negedge clk);
			g++;
		end
		{wr, flag_select_n, addr, wd, be} = {w, s, a, d, b};
		req = 1;
		while (done !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
			if (k == 1) req = 0;
		end
		if (g >= 50 || k >= 100) begin
			bad_count++;
			results();
		end
	endtask
	task automatic t_array();
		op(1, 0, 13'h0010, 16'hFFFF, 2'h3, n);
		chk(16'(n), 16'h0006);
		op(1, 0, 13'h0010, 16'h1234, 2'h1, n);
		op(0, 0, 13'h0010, 16'h0000, 2'h0, n);
		chk(rdata, 16'hFF34);
		chk(16'(n), 16'h0009);
		op(1, 0, 13'h1FFF, 16'hABCD, 2'h0, n);
		op(0, 0, 13'h1FFF, 16'h0000, 2'h0, n);
		chk(rdata, 16'hABCD);
		$display("test array done");
	endtask
	task automatic t_sem();
		for (int v = 0; v < 2; v++) begin
			op(1, 1, 13'h0003, 16'(v), 2'h0, n);
			op(0, 1, 13'h0003, 16'h0000, 2'h0, n);
			chk(rdata, {16{v[0]}});
		end
		$display("test semaphore done");
	endtask
	// Busy low before the strobe starts must stretch the write and keep it
	task automatic t_busy();
		// Peer claim lands before our strobe, so this port loses arbitration
		busy_cmd = 0;
		fork
			op(1, 0, 13'h0020, 16'h5AA5, 2'h3, n);
			begin
				repeat (10) @(negedge clk);
				busy_cmd = 1;
			end
		join
		chk(16'(n >= 17), 16'h0001);
		op(0, 0, 13'h0020, 16'h0000, 2'h0, n);
		chk(rdata, 16'h5AA5);
		$display("test busy done");
	endtask
	// Reset in the setup phase must drop the write strobe, both selects and data drive, and lose nothing
	task automatic t_reset();
		@(negedge clk);
		{wr, flag_select_n, addr, wd, be} = {1'b1, 1'b0, 13'h0010, 16'h0000, 2'h3};
		req = 1;
		@(negedge clk);
		req = 0;
		nrst = 0;
		#1;
		chk({we_n, ps_n, fs_n, hoe_n, ready, done}, 16'h003E);
		chk(16'(paddr), 16'h0000);
		repeat (2) @(negedge clk);
		nrst = 1;
		op(0, 0, 13'h0010, 16'h0000, 2'h0, n);
		chk(rdata, 16'hFF34);
		$display("test reset done");
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1;
		t_array();
		t_sem();
		t_busy();
		t_reset();
		results();
	end
endmodule
